// >>> verilog/jfs_isp_top.sv
// Test-port flash sequencer: ISP instructions, two flash arrays, user chains, pin control
// Behaviour
// - A user chain instruction routes the serial input through user logic.
// - Each of the two user instructions selects its own user chain.
// - Port signals and controller state go to user logic while selected.
// - Programming uses only the four test port signals.
// - In programming mode every pin floats with weak pull-up.
// - Pins never drive until the completion flag is programmed last.
// - Instructions, addresses, data shift in on input; read data out on output.
// - Pins switch cleanly into programming mode and back out.
// - Erase pulse is 500 ms made during run-test-idle.
// - Program pulse is 75 us made during run-test-idle, per word.
// - Verify makes a read pulse; read data then shifts out.
// - User and configuration arrays change independently of each other.
// - Instruction register is 10 bits long.
// - User chain instructions are 00 0000 1100 and 00 0000 1110.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "jfs_map.svh"
module jfs_isp_top
  import jfs_pkg::*;
#(
  parameter int unsigned          ERASE_CYCLES = `JFS_ERASE_CYCLES,
  parameter logic [`JFS_ID_LEN-1:0] ID_CODE    = `JFS_ID_DEFAULT
) (
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  tck,
  input  wire logic  tms,
  input  wire logic  tdi,
  output logic       tdo,
  output logic       tdo_oe_n,
  output jfs_usr_type usr,
  input  wire logic  usr_tdo_a,
  input  wire logic  usr_tdo_b,
  output logic       io_drive_en,
  output logic       io_pullup_en,
  output logic       programming_complete_flag
);
  // ID_CODE default is arbitrary
  localparam logic [31:0] PROG_NEED = 32'(`JFS_PROG_CYCLES);
  localparam logic [31:0] READ_NEED = 32'(`JFS_READ_CYCLES);
  localparam logic [31:0] ERASE_NEED = 32'(ERASE_CYCLES);

  function automatic jfs_tap_type jfs_tap_next(input jfs_tap_type s, input logic m);
    case (s)
      JFS_TAP_TLR:    jfs_tap_next = m ? JFS_TAP_TLR    : JFS_TAP_RTI;
      JFS_TAP_RTI:    jfs_tap_next = m ? JFS_TAP_SEL_DR : JFS_TAP_RTI;
      JFS_TAP_SEL_DR: jfs_tap_next = m ? JFS_TAP_SEL_IR : JFS_TAP_CAP_DR;
      JFS_TAP_CAP_DR: jfs_tap_next = m ? JFS_TAP_EX1_DR : JFS_TAP_SH_DR;
      JFS_TAP_SH_DR:  jfs_tap_next = m ? JFS_TAP_EX1_DR : JFS_TAP_SH_DR;
      JFS_TAP_EX1_DR: jfs_tap_next = m ? JFS_TAP_UP_DR  : JFS_TAP_PA_DR;
      JFS_TAP_PA_DR:  jfs_tap_next = m ? JFS_TAP_EX2_DR : JFS_TAP_PA_DR;
      JFS_TAP_EX2_DR: jfs_tap_next = m ? JFS_TAP_UP_DR  : JFS_TAP_SH_DR;
      JFS_TAP_UP_DR:  jfs_tap_next = m ? JFS_TAP_SEL_DR : JFS_TAP_RTI;
      JFS_TAP_SEL_IR: jfs_tap_next = m ? JFS_TAP_TLR    : JFS_TAP_CAP_IR;
      JFS_TAP_CAP_IR: jfs_tap_next = m ? JFS_TAP_EX1_IR : JFS_TAP_SH_IR;
      JFS_TAP_SH_IR:  jfs_tap_next = m ? JFS_TAP_EX1_IR : JFS_TAP_SH_IR;
      JFS_TAP_EX1_IR: jfs_tap_next = m ? JFS_TAP_UP_IR  : JFS_TAP_PA_IR;
      JFS_TAP_PA_IR:  jfs_tap_next = m ? JFS_TAP_EX2_IR : JFS_TAP_PA_IR;
      JFS_TAP_EX2_IR: jfs_tap_next = m ? JFS_TAP_UP_IR  : JFS_TAP_SH_IR;
      JFS_TAP_UP_IR:  jfs_tap_next = m ? JFS_TAP_SEL_DR : JFS_TAP_RTI;
      default:        jfs_tap_next = JFS_TAP_TLR;
    endcase
  endfunction

  // Shift one bit in at the top of a chain of the given length
  function automatic logic [31:0] jfs_shift_in(input logic [31:0] v, input logic b,
                                               input logic [5:0] len);
    logic [31:0] r;
    r = {1'b0, v[31:1]};
    r[5'(len - 6'h01)] = b;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Test clock domain
  logic [1:0]                tck_rst_pipe;
  logic                      tck_rst_n;
  jfs_tap_type               tap;
  jfs_tap_type               next_tap;
  logic [`JFS_IR_LEN-1:0]    ir;
  logic [`JFS_IR_LEN-1:0]    ir_shift;
  logic [31:0]               dr_shift;
  logic [`JFS_ADDR_LEN-1:0]  addr_reg;
  logic [`JFS_DATA_LEN-1:0]  data_reg;
  logic [`JFS_DATA_LEN-1:0]  rdata_hold;
  logic                      isp_mode;
  logic                      ack_seen;
  logic                      ack_s;
  jfs_cmd_type               cmd_tck;
  logic                      exec_tck;
  logic [`JFS_DATA_LEN-1:0]  rdata_word;
  logic                      ack_tgl;

  // Reset enters asynchronously, leaves the test clock domain in step
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tck_rst_pipe <= 2'h0;
    end else begin
      tck_rst_pipe <= {tck_rst_pipe[0], 1'b1};
    end
  end
  assign tck_rst_n = tck_rst_pipe[1];

  wire sel_user_a = (ir == `JFS_INS_USER_A);
  wire sel_user_b = (ir == `JFS_INS_USER_B);
  wire sel_id     = (ir == `JFS_INS_IDCODE);
  wire sel_addr   = (ir == `JFS_INS_ADDR);
  wire sel_data   = (ir == `JFS_INS_PROG) || (ir == `JFS_INS_VERIFY);
  wire shift_ir   = (tap == JFS_TAP_SH_IR);
  wire shift_dr   = (tap == JFS_TAP_SH_DR);

  // Unknown codes fall back to the one-bit bypass chain
  wire [5:0] dr_len = sel_id   ? 6'h20 :
                      sel_data ? 6'h10 :
                      sel_addr ? 6'h08 : 6'h01;
  wire jfs_op_type ir_op = (ir == `JFS_INS_ERASE_CFG) ? JFS_OP_ERASE_CFG :
                           (ir == `JFS_INS_ERASE_UFM) ? JFS_OP_ERASE_UFM :
                           (ir == `JFS_INS_PROG)      ? JFS_OP_PROG :
                           (ir == `JFS_INS_VERIFY)    ? JFS_OP_READ :
                           (ir == `JFS_INS_DONE)      ? JFS_OP_DONE : JFS_OP_NONE;
  wire [31:0] dr_capture = sel_id   ? ID_CODE :
                           sel_data ? 32'(rdata_hold) :
                           sel_addr ? 32'(addr_reg) : 32'h0;
  wire tdo_bit = shift_ir   ? ir_shift[0] :
                 sel_user_a ? usr_tdo_a :
                 sel_user_b ? usr_tdo_b : dr_shift[0];

  assign next_tap = jfs_tap_next(tap, tms);

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tap <= JFS_TAP_TLR;
    end else begin
      tap <= next_tap;
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ir_shift <= `JFS_IR_CAPTURE;
      ir       <= `JFS_INS_IDCODE;
    end else begin
      if (tap == JFS_TAP_CAP_IR) begin
        ir_shift <= `JFS_IR_CAPTURE;
      end else if (shift_ir) begin
        ir_shift <= 10'(jfs_shift_in(32'(ir_shift), tdi, 6'(`JFS_IR_LEN)));
      end
      if (tap == JFS_TAP_TLR) begin
        ir <= `JFS_INS_IDCODE;
      end else if (tap == JFS_TAP_UP_IR) begin
        ir <= ir_shift;
      end
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      dr_shift <= 32'h0;
    end else if (tap == JFS_TAP_CAP_DR) begin
      dr_shift <= dr_capture;
    end else if (shift_dr) begin
      dr_shift <= jfs_shift_in(dr_shift, tdi, dr_len);
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      addr_reg <= 8'h00;
      data_reg <= `JFS_ERASED_WORD;
    end else if (tap == JFS_TAP_UP_DR) begin
      if (sel_addr) begin
        addr_reg <= dr_shift[`JFS_ADDR_LEN-1:0];
      end else if (ir == `JFS_INS_PROG) begin
        data_reg <= dr_shift[`JFS_DATA_LEN-1:0];
      end
    end
  end

  // Mode changes only on the instruction update, never mid-scan
  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      isp_mode <= 1'b0;
    end else if (tap == JFS_TAP_UP_IR) begin
      if (ir_shift == `JFS_INS_ENTER) begin
        isp_mode <= 1'b1;
      end else if (ir_shift == `JFS_INS_EXIT) begin
        isp_mode <= 1'b0;
      end
    end
  end

  // Request rises one idle cycle late, so the update edge has settled ir and data first
  // Command freezes while the request stands, so the far side may sample it late
  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      cmd_tck  <= '{op: JFS_OP_NONE, addr: 8'h00, data: `JFS_ERASED_WORD};
      exec_tck <= 1'b0;
    end else begin
      if (!exec_tck) begin
        cmd_tck <= '{op: ir_op, addr: addr_reg, data: data_reg};
      end
      exec_tck <= (tap == JFS_TAP_RTI) && (next_tap == JFS_TAP_RTI) && isp_mode &&
                  (ir_op != JFS_OP_NONE);
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      ack_seen   <= 1'b0;
      rdata_hold <= `JFS_ERASED_WORD;
    end else if (ack_s != ack_seen) begin
      ack_seen   <= ack_s;
      rdata_hold <= rdata_word;
    end
  end

  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      usr <= '0;
    end else begin
      usr.sel_a   <= sel_user_a;
      usr.sel_b   <= sel_user_b;
      usr.tdi     <= tdi;
      usr.tms     <= tms;
      usr.capture <= (sel_user_a || sel_user_b) && (next_tap == JFS_TAP_CAP_DR);
      usr.shift   <= (sel_user_a || sel_user_b) && (next_tap == JFS_TAP_SH_DR);
      usr.update  <= (sel_user_a || sel_user_b) && (next_tap == JFS_TAP_UP_DR);
      usr.rti     <= (next_tap == JFS_TAP_RTI);
      usr.tlr     <= (next_tap == JFS_TAP_TLR);
    end
  end

  // Output changes on the falling edge so the far end samples it half a period later
  always_ff @(negedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo      <= tdo_bit;
      tdo_oe_n <= !(shift_ir || shift_dr);
    end
  end

  jfs_sync u_ack_sync (
    .clk   (tck),
    .rst_n (tck_rst_n),
    .d     (ack_tgl),
    .q     (ack_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reference clock domain
  logic                     exec_s;
  logic                     isp_s;
  jfs_seq_type              seq;
  jfs_seq_type              next_seq;
  logic [31:0]              count;
  logic [31:0]              next_count;
  jfs_cmd_type              cmd_ref;
  logic [`JFS_DATA_LEN-1:0] cfg_rdata;
  logic [`JFS_DATA_LEN-1:0] ufm_rdata;

  jfs_sync u_exec_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (exec_tck),
    .q     (exec_s)
  );

  jfs_sync u_isp_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (isp_mode),
    .q     (isp_s)
  );

  wire [31:0] pulse_need = (cmd_ref.op == JFS_OP_ERASE_CFG || cmd_ref.op == JFS_OP_ERASE_UFM) ? ERASE_NEED :
                           (cmd_ref.op == JFS_OP_READ) ? READ_NEED : PROG_NEED;
  wire in_pulse  = (seq == JFS_SEQ_PULSE);
  wire commit    = in_pulse && exec_s && (count == pulse_need - 32'h1);
  wire ufm_sel   = cmd_ref.addr[`JFS_ADDR_ARRAY_BIT];
  wire erase_cfg = commit && (cmd_ref.op == JFS_OP_ERASE_CFG);
  wire erase_ufm = commit && (cmd_ref.op == JFS_OP_ERASE_UFM);
  wire prog_word = commit && (cmd_ref.op == JFS_OP_PROG);
  wire rd_commit = commit && (cmd_ref.op == JFS_OP_READ);
  wire set_done  = commit && (cmd_ref.op == JFS_OP_DONE);

  // Leaving run-test-idle early aborts the pulse and leaves the cells alone
  always_comb begin
    next_seq   = seq;
    next_count = count;
    case (seq)
      JFS_SEQ_IDLE: begin
        if (exec_s && isp_s) begin
          next_seq   = JFS_SEQ_PULSE;
          next_count = 32'h0;
        end
      end
      JFS_SEQ_PULSE: begin
        if (!exec_s) begin
          next_seq = JFS_SEQ_IDLE;
        end else if (commit) begin
          next_seq = JFS_SEQ_HOLD;
        end else begin
          next_count = count + 32'h1;
        end
      end
      JFS_SEQ_HOLD: begin
        if (!exec_s) begin
          next_seq = JFS_SEQ_IDLE;
        end
      end
      default: begin
        next_seq = JFS_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq   <= JFS_SEQ_IDLE;
      count <= 32'h0;
    end else begin
      seq   <= next_seq;
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ref <= '{op: JFS_OP_NONE, addr: 8'h00, data: `JFS_ERASED_WORD};
    end else if ((seq == JFS_SEQ_IDLE) && exec_s && isp_s) begin
      cmd_ref <= cmd_tck;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_word <= `JFS_ERASED_WORD;
      ack_tgl    <= 1'b0;
    end else if (rd_commit) begin
      rdata_word <= ufm_sel ? ufm_rdata : cfg_rdata;
      ack_tgl    <= !ack_tgl;
    end
  end

  // Erasing the configuration array also clears the completion flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      programming_complete_flag <= 1'b0;
    end else if (set_done) begin
      programming_complete_flag <= 1'b1;
    end else if (erase_cfg) begin
      programming_complete_flag <= 1'b0;
    end
  end

  // Both pin controls flip on one edge, so no pin sees a mixed state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_drive_en  <= 1'b0;
      io_pullup_en <= 1'b1;
    end else begin
      io_drive_en  <= !isp_s && programming_complete_flag;
      io_pullup_en <= isp_s || !programming_complete_flag;
    end
  end

  jfs_flash_bank #(
    .WORDS        (`JFS_CFG_WORDS),
    .SECTOR_WORDS (`JFS_CFG_WORDS)
  ) u_cfg_bank (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .erase (erase_cfg),
    .sector(1'b0),
    .prog  (prog_word && !ufm_sel),
    .addr  (cmd_ref.addr[`JFS_CFG_AW-1:0]),
    .wdata (cmd_ref.data),
    .rdata (cfg_rdata)
  );

  jfs_flash_bank #(
    .WORDS        (`JFS_UFM_WORDS),
    .SECTOR_WORDS (`JFS_UFM_SECTOR_WORDS)
  ) u_ufm_bank (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .erase (erase_ufm),
    .sector(cmd_ref.addr[`JFS_UFM_SECTOR_BIT]),
    .prog  (prog_word && ufm_sel),
    .addr  (cmd_ref.addr[`JFS_UFM_AW-1:0]),
    .wdata (cmd_ref.data),
    .rdata (ufm_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_user_a_route;
    @(negedge tck) disable iff (!tck_rst_n)
    (shift_dr && sel_user_a) |-> ##1 (tdo == $past(usr_tdo_a));
  endproperty
  a_user_a_route: assert property (p_user_a_route) else $error("user chain a not on tdo");

  property p_user_b_route;
    @(negedge tck) disable iff (!tck_rst_n)
    (shift_dr && sel_user_b) |-> ##1 (tdo == $past(usr_tdo_b));
  endproperty
  a_user_b_route: assert property (p_user_b_route) else $error("user chain b not on tdo");

  property p_usr_shift_state;
    @(posedge tck) disable iff (!tck_rst_n)
    usr.shift |-> (tap == JFS_TAP_SH_DR) && (usr.sel_a || usr.sel_b);
  endproperty
  a_usr_shift_state: assert property (p_usr_shift_state) else $error("user shift out of step");

  property p_ir_update;
    @(posedge tck) disable iff (!tck_rst_n)
    $changed(ir) |-> $past(tap) == JFS_TAP_UP_IR || $past(tap) == JFS_TAP_TLR;
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction changed outside update");

  property p_user_code;
    @(posedge tck) disable iff (!tck_rst_n)
    $rose(usr.sel_a) |-> $past(ir) == `JFS_INS_USER_A;
  endproperty
  a_user_code: assert property (p_user_code) else $error("user chain a selected by wrong code");

  property p_isp_pins;
    @(posedge ref_clk) disable iff (!rst_n)
    isp_s |=> !io_drive_en && io_pullup_en;
  endproperty
  a_isp_pins: assert property (p_isp_pins) else $error("pins not floating in programming mode");

  property p_no_drive;
    @(posedge ref_clk) disable iff (!rst_n)
    !programming_complete_flag |=> !io_drive_en;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pins driven before completion flag");

  property p_erase_abort;
    @(posedge ref_clk) disable iff (!rst_n)
    (in_pulse && !exec_s) |=> (seq == JFS_SEQ_IDLE) && $stable(programming_complete_flag);
  endproperty
  a_erase_abort: assert property (p_erase_abort) else $error("aborted pulse still acted");

  property p_prog_pulse;
    @(posedge ref_clk) disable iff (!rst_n)
    prog_word |-> $past(in_pulse, 8) && $past(exec_s, 8);
  endproperty
  a_prog_pulse: assert property (p_prog_pulse) else $error("program pulse too short");

  property p_read_ack;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_commit |=> (ack_tgl != $past(ack_tgl)) &&
                  (rdata_word == ($past(ufm_sel) ? $past(ufm_rdata) : $past(cfg_rdata)));
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read pulse gave no data");
endmodule
`default_nettype wire

// >>> verilog/jfs_map.svh
// Instruction codes, sizes and pulse timing of the flash sequencer
`ifndef JFS_MAP_SVH
`define JFS_MAP_SVH
`define JFS_IR_LEN          10
`define JFS_IR_CAPTURE      10'h001
`define JFS_INS_BYPASS      10'h3FF
`define JFS_INS_IDCODE      10'h006
`define JFS_INS_USER_A      10'h00C
`define JFS_INS_USER_B      10'h00E
`define JFS_INS_ENTER       10'h2CC
`define JFS_INS_EXIT        10'h201
`define JFS_INS_ADDR        10'h203
`define JFS_INS_ERASE_CFG   10'h2F2
`define JFS_INS_ERASE_UFM   10'h2F3
`define JFS_INS_PROG        10'h2F4
`define JFS_INS_VERIFY      10'h205
`define JFS_INS_DONE        10'h2F6
`define JFS_ID_DEFAULT      32'h0000_0001
`define JFS_ID_LEN          32
`define JFS_ADDR_LEN        8
`define JFS_ADDR_ARRAY_BIT  7
`define JFS_DATA_LEN        16
`define JFS_CFG_WORDS       16
`define JFS_CFG_AW          4
`define JFS_UFM_WORDS       32
`define JFS_UFM_AW          5
`define JFS_UFM_SECTOR_WORDS 16
`define JFS_UFM_SECTOR_BIT  4
`define JFS_ERASED_WORD     16'hFFFF
`define JFS_REF_HZ          10_000_000
`define JFS_ERASE_MS        500
`define JFS_PROG_US         75
`define JFS_ERASE_CYCLES    (`JFS_ERASE_MS * (`JFS_REF_HZ / 1000))
`define JFS_PROG_CYCLES     ((`JFS_PROG_US * `JFS_REF_HZ + 999_999) / 1_000_000)
`define JFS_READ_CYCLES     2
`endif

// >>> verilog/jfs_pkg.sv
// Types shared by the flash sequencer files
`default_nettype none
`include "jfs_map.svh"
package jfs_pkg;
  typedef enum logic [15:0] {
    JFS_TAP_TLR    = 16'h0001,
    JFS_TAP_RTI    = 16'h0002,
    JFS_TAP_SEL_DR = 16'h0004,
    JFS_TAP_CAP_DR = 16'h0008,
    JFS_TAP_SH_DR  = 16'h0010,
    JFS_TAP_EX1_DR = 16'h0020,
    JFS_TAP_PA_DR  = 16'h0040,
    JFS_TAP_EX2_DR = 16'h0080,
    JFS_TAP_UP_DR  = 16'h0100,
    JFS_TAP_SEL_IR = 16'h0200,
    JFS_TAP_CAP_IR = 16'h0400,
    JFS_TAP_SH_IR  = 16'h0800,
    JFS_TAP_EX1_IR = 16'h1000,
    JFS_TAP_PA_IR  = 16'h2000,
    JFS_TAP_EX2_IR = 16'h4000,
    JFS_TAP_UP_IR  = 16'h8000
  } jfs_tap_type;
  typedef enum logic [2:0] {
    JFS_SEQ_IDLE  = 3'h1,
    JFS_SEQ_PULSE = 3'h2,
    JFS_SEQ_HOLD  = 3'h4
  } jfs_seq_type;
  typedef enum logic [5:0] {
    JFS_OP_NONE      = 6'h01,
    JFS_OP_ERASE_CFG = 6'h02,
    JFS_OP_ERASE_UFM = 6'h04,
    JFS_OP_PROG      = 6'h08,
    JFS_OP_READ      = 6'h10,
    JFS_OP_DONE      = 6'h20
  } jfs_op_type;
  typedef struct packed {
    jfs_op_type                 op;
    logic [`JFS_ADDR_LEN-1:0]   addr;
    logic [`JFS_DATA_LEN-1:0]   data;
  } jfs_cmd_type;
  typedef struct packed {
    logic sel_a;
    logic sel_b;
    logic tdi;
    logic tms;
    logic capture;
    logic shift;
    logic update;
    logic rti;
    logic tlr;
  } jfs_usr_type;
endpackage
`default_nettype wire

// >>> verilog/jfs_sync.sv
// Three-stage synchroniser that passes a level once two stages agree
`timescale 1ns/1ps
`default_nettype none
module jfs_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic [2:0] pipe;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe <= 3'h0;
      q    <= 1'b0;
    end else begin
      pipe <= {pipe[1:0], d};
      if (pipe[1] == pipe[2]) begin
        q <= pipe[2];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/jfs_flash_bank.sv
// One flash array in flip-flops: sector erase, word program, word read
`timescale 1ns/1ps
`default_nettype none
`include "jfs_map.svh"
module jfs_flash_bank #(
  parameter int unsigned WORDS        = 16,
  parameter int unsigned SECTOR_WORDS = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     erase,
  input  wire logic                     sector,
  input  wire logic                     prog,
  input  wire logic [$clog2(WORDS)-1:0] addr,
  input  wire logic [`JFS_DATA_LEN-1:0] wdata,
  output logic      [`JFS_DATA_LEN-1:0] rdata
);
  logic [WORDS-1:0][`JFS_DATA_LEN-1:0] mem;
  // Blank array after reset; programming can only clear bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem <= {WORDS{`JFS_ERASED_WORD}};
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        if (erase && ((i / SECTOR_WORDS) == int'(sector))) begin
          mem[i] <= `JFS_ERASED_WORD;
        end
      end
      if (prog) begin
        mem[addr] <= mem[addr] & wdata;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `JFS_ERASED_WORD;
    end else begin
      rdata <= mem[addr];
    end
  end
  property p_bank_quiet;
    @(posedge clk) disable iff (!rst_n)
    !$past(erase) && !$past(prog) |-> $stable(mem);
  endproperty
  a_bank_quiet: assert property (p_bank_quiet) else $error("flash cells changed with no request");
endmodule
`default_nettype wire

// >>> bench/jfs_prog_model.sv
// Programmer model: drives the test port and samples tdo
`timescale 1ns/1ps
`default_nettype none
module jfs_prog_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  logic        smp;
  logic [31:0] got;
  initial {tck, tms, tdi} = 3'h0;
  // Clock stands low between frames; tdi toggles when unused
  task automatic step(input logic m, input logic v);
    tms = m;
    tdi = v;
    #62.5 smp = tdo;
    tck = 1'h1;
    #62.5 tck = 1'h0;
  endtask
  task automatic idle(input int n);
    repeat (n) step(1'h0, ~tdi);
  endtask
  task automatic tlr();
    repeat (5) step(1'h1, ~tdi);
    idle(1);
  endtask
  // LSB first, read-back sampled before each shift edge
  task automatic scan(input logic ir, input logic [31:0] v, input int n);
    step(1'h1, ~tdi);
    if (ir) step(1'h1, ~tdi);
    idle(2);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i]);
      got[i] = smp;
    end
    step(1'h1, ~tdi);
    idle(1);
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Bench: programs, verifies and exits the flash sequencer over the test port
`timescale 1ns/1ps
`default_nettype none
`include "jfs_map.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  import jfs_pkg::*;
  localparam logic [31:0] ID = 32'h5A5A_0F01; // Arbitrary identity value
  logic        ref_clk = 1'h0, rst_n = 1'h0, ua = 1'h0, ub = 1'h0;
  logic [31:0] q;
  wire logic   tck, tms, tdi, tdo, oe_n, drv, pu, flag;
  jfs_usr_type usr;
  int          seed = 9, n_mismatch = 0, compares = 0, cyc = 0, d;
  int          mem [2];
  always #50 ref_clk = ~ref_clk;
  jfs_isp_top #(.ERASE_CYCLES(20), .ID_CODE(ID)) jfs_isp_top_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(oe_n), .usr(usr), .usr_tdo_a(ua),
    .usr_tdo_b(ub), .io_drive_en(drv), .io_pullup_en(pu), .programming_complete_flag(flag));
  jfs_prog_model jfs_prog_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Run needs about 3700 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic sc(input logic ir, input logic [31:0] v, input int n);
    jfs_prog_model_inst.scan(ir, v, n);
    q = jfs_prog_model_inst.got;
  endtask
  task automatic op(input logic [9:0] c, input int n);
    sc(1'h1, c, 10);
    jfs_prog_model_inst.idle(n);
  endtask
  task automatic idchk();
    op(`JFS_INS_IDCODE, 1);
    sc(1'h0, 0, 32);
    `CHK("idcode", ID, q)
  endtask
  task automatic vfy();
    for (int k = 0; k < 2; k++) begin
      op(`JFS_INS_ADDR, 1);
      sc(1'h0, {k[0], 7'h03}, 8);
      op(`JFS_INS_VERIFY, 24);
      sc(1'h0, 0, 16);
      `CHK("word", mem[k][15:0], q[15:0])
    end
  endtask
  initial begin
    fork
      repeat (3) @(posedge ref_clk);
      jfs_prog_model_inst.idle(3);
    join
    @(posedge ref_clk);
    rst_n <= 1'h1;
    jfs_prog_model_inst.tlr();
    sc(1'h1, `JFS_INS_IDCODE, 10);
    `CHK("ir capture", 10'h001, q[9:0])
    sc(1'h0, 0, 32);
    `CHK("idcode", ID, q)
    `CHK("tdo enable", 1'h1, oe_n)
    $display("test idcode done");
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      @(posedge ref_clk);
      ua <= d[0];
      ub <= ~d[0];
      sc(1'h1, k ? 10'h00E : 10'h00C, 10);
      jfs_prog_model_inst.idle(1);
      `CHK("usr", {k == 0, k == 1, tdi, 4'h0, 2'h2}, usr)
      sc(1'h0, 0, 8);
      `CHK("chain", {8{d[0] ^ k[0]}}, q[7:0])
    end
    $display("test user chains done");
    op(`JFS_INS_ENTER, 20);
    `CHK("isp pins", 2'h1, {drv, pu})
    idchk();
    op(`JFS_INS_ERASE_CFG, 40);
    op(`JFS_INS_ERASE_UFM, 40);
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      mem[k] = 16'hFFFF & d;
      op(`JFS_INS_ADDR, 1);
      sc(1'h0, {k[0], 7'h03}, 8);
      op(`JFS_INS_PROG, 1);
      sc(1'h0, d, 16);
      jfs_prog_model_inst.idle(640);
    end
    vfy();
    op(`JFS_INS_EXIT, 20);
    `CHK("pins no flag", 3'h2, {drv, pu, flag})
    op(`JFS_INS_ENTER, 20);
    idchk();
    vfy();
    op(`JFS_INS_DONE, 640);
    op(`JFS_INS_EXIT, 20);
    `CHK("user pins", 3'h5, {drv, pu, flag})
    $display("test programming_complete_flag");
    report_and_stop();
  end
endmodule
`default_nettype wire
